/* pkg/dshp_regs.svh */
// register offsets, field positions, reset values and timing for the slot hot-plug controller
// Overview of operation
// [RULE1] one controller per downstream port, enabled by capability
// [RULE2] slot signals exchanged through expander port
// [RULE3] presence only from presence input pin
// [RULE4] global per-signal polarity invert bits
// [RULE5] interlock pulse between 100 and 150 ms
// [RULE6] toggle mode inverts interlock per write
// [RULE7] latch input reported as interlock status
// [RULE8] latch state reads closed in that mode
// [RULE9] otherwise interlock status mirrors interlock output
// [RULE10] auto power off when latch open
// [RULE11] default load never sets command completed
// [RULE12] interrupts only with hot-plug enable set
// [RULE13] five status flags raise unmasked interrupt
// [RULE14] delivery as MSI or INTx per bits
// [RULE15] D3hot wake rules for PME and interrupt
// [RULE16] command completed never wakes
// [RULE17] general event mode replaces INTx MSI PME
// [RULE18] general event pin only in alternate function
// [RULE19] general event status set only in mode
// [RULE20] other bits behave normally in event mode
// [RULE21] slot reset is a GPIO alternate function
// [RULE22] outputs released while in reset
// [RULE23] pulse timer uses tick divider
// [RULE24] flags sticky, write one clears
`ifndef DSHP_REGS_SVH
`define DSHP_REGS_SVH
`define DSHP_ADDR_HP_CFG      8'h00
`define DSHP_ADDR_GPE_CTL     8'h04
`define DSHP_ADDR_GPE_STS     8'h08
`define DSHP_ADDR_MISC        8'h0C
`define DSHP_ADDR_PORT_BASE   8'h10
`define DSHP_PORT_STRIDE      8'h10
`define DSHP_OFS_CAP          4'h0
`define DSHP_OFS_CTL          4'h4
`define DSHP_OFS_STS          4'h8
// slot_capabilities bits
`define DSHP_CAP_ATTN_BTN     0
`define DSHP_CAP_PWR_CTL      1
`define DSHP_CAP_LATCH        2
`define DSHP_CAP_ATTN_IND     3
`define DSHP_CAP_PWR_IND      4
`define DSHP_CAP_PRESENT      6
`define DSHP_CAP_ILOCK        17
// slot_control bits
`define DSHP_CTL_ABP_EN       0
`define DSHP_CTL_PFD_EN       1
`define DSHP_CTL_LATCH_CHANGED_FLAG_EN     2
`define DSHP_CTL_PDC_EN       3
`define DSHP_CTL_CC_EN        4
`define DSHP_CTL_HOTPLUG_IRQ_ENABLE         5
`define DSHP_CTL_AIND_LO      6
`define DSHP_CTL_PIND_LO      8
`define DSHP_CTL_PCC          10
`define DSHP_CTL_EIC          11
// slot_status bits
`define DSHP_STS_ABP          0
`define DSHP_STS_PFD          1
`define DSHP_STS_LATCH_CHANGED_FLAG        2
`define DSHP_STS_PDC          3
`define DSHP_STS_CC           4
`define DSHP_STS_LATCH        5
`define DSHP_STS_PRES         6
`define DSHP_STS_EIS          7
// hotplug_config_control bits
`define DSHP_CFG_INV_LO       0
`define DSHP_CFG_TOGGLE       8
`define DSHP_CFG_LATCH_ILOCK  9
`define DSHP_CFG_AUTO_OFF     10
`define DSHP_CFG_RESET        32'h0000_0000
`define DSHP_CAP_RESET        32'h0000_0000
// interlock pulse: 125 ms target inside 100..150 ms window
`define DSHP_PULSE_MS         125
`define DSHP_CLK_HZ           25000000
`define DSHP_TICK_HZ          1000
`endif

/* pkg/dshp_pkg.sv */
// types for the slot hot-plug controller
package dshp_pkg;
	typedef logic [31:0] dshp_word_t;
	typedef enum logic [1:0] {
		DSHP_PWR_ON,
		DSHP_PWR_OFF,
		DSHP_PWR_AUTO_OFF
	} dshp_pwr_e;
endpackage : dshp_pkg

/* rtl/dshp_ctrl.sv */
// slot hot-plug controller for all downstream ports
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "dshp_regs.svh"
module dshp_ctrl #(
	parameter int NPORT      = 5,
	parameter int TICK_DIV   = `DSHP_CLK_HZ / `DSHP_TICK_HZ,
	parameter int PULSE_TICK = `DSHP_PULSE_MS
) (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire logic [7:0]           reg_addr,
	input  wire dshp_pkg::dshp_word_t reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	input  wire logic [NPORT-1:0]     attention_button_in,
	input  wire logic [NPORT-1:0]     presence_detect_in,
	input  wire logic [NPORT-1:0]     power_fault_in,
	input  wire logic [NPORT-1:0]     retention_latch_in,
	input  wire logic [NPORT-1:0]     slot_power_good_in,
	input  wire logic [NPORT-1:0]     expander_ready_in,
	output logic      [NPORT-1:0]     attention_indicator_out,
	output logic      [NPORT-1:0]     power_indicator_out,
	output logic      [NPORT-1:0]     slot_power_enable_out,
	output logic      [NPORT-1:0]     interlock_out,
	output logic      [NPORT-1:0]     slot_reset_out,
	output logic      [NPORT-1:0]     hp_outputs_oe,
	output logic      [NPORT-1:0]     msi_req,
	output logic      [NPORT-1:0]     intx_req,
	output logic      [NPORT-1:0]     pme_req,
	output logic                      general_event_out,
	output logic                      general_event_oe,
	input  wire logic [NPORT-1:0]     msi_enable,
	input  wire logic [NPORT-1:0]     legacy_irq_disable,
	input  wire logic [NPORT-1:0]     d3hot,
	input  wire logic                 gpio_alt_func,
	input  wire logic [NPORT-1:0]     slot_reset_req
);
	import dshp_pkg::*;

	localparam int TW = $clog2(TICK_DIV + 1);

	////////////////////////////////////////////////////////////////////////////
	// register state
	logic [31:0]      hotplug_config_control;
	logic [NPORT-1:0] general_event_control;
	logic [NPORT-1:0] general_event_status;
	logic [31:0]      slot_capabilities [NPORT];
	logic [11:0]      slot_control      [NPORT];
	logic [4:0]       flags             [NPORT];
	logic [NPORT-1:0] ilock;
	logic [7:0]       pulse_cnt         [NPORT];
	logic [TW-1:0]    tick_cnt;
	logic             tick;
	logic [NPORT-1:0] pres_q;
	logic [NPORT-1:0] latch_q;
	logic [NPORT-1:0] btn_q;
	logic [NPORT-1:0] fault_q;

	function automatic logic port_hit(input logic [7:0] a, input int p, input logic [3:0] o);
		port_hit = (a == 8'(`DSHP_ADDR_PORT_BASE + p * `DSHP_PORT_STRIDE + o));
	endfunction : port_hit

	function automatic logic inv(input logic s, input int b);
		inv = s ^ hotplug_config_control[`DSHP_CFG_INV_LO + b];
	endfunction : inv

	// conditioned inputs after polarity select
	logic [NPORT-1:0] pres_i;
	logic [NPORT-1:0] latch_i;
	logic [NPORT-1:0] btn_i;
	logic [NPORT-1:0] fault_i;
	logic [NPORT-1:0] active;
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			// [RULE4] global polarity invert
			btn_i[p]   = inv(attention_button_in[p], 0);
			// [RULE3] presence from pin only
			pres_i[p]  = inv(presence_detect_in[p], 1);
			fault_i[p] = inv(power_fault_in[p], 2);
			latch_i[p] = inv(retention_latch_in[p], 3);
			// [RULE1] controller present gate
			active[p]  = slot_capabilities[p][`DSHP_CAP_PRESENT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// [RULE23] tick divider for interlock timing
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= '0;
			tick     <= 1'b0;
		end else if (tick_cnt == TW'(TICK_DIV - 1)) begin
			tick_cnt <= '0;
			tick     <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
			tick     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// global and per-port configuration registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hotplug_config_control <= `DSHP_CFG_RESET;
			general_event_control  <= '0;
			for (int p = 0; p < NPORT; p++) begin
				slot_capabilities[p] <= `DSHP_CAP_RESET;
				slot_control[p]      <= '0;
			end
		end else if (reg_wr) begin
			if (reg_addr == `DSHP_ADDR_HP_CFG)
				hotplug_config_control <= reg_wdata;
			if (reg_addr == `DSHP_ADDR_GPE_CTL)
				general_event_control <= reg_wdata[NPORT-1:0];
			for (int p = 0; p < NPORT; p++) begin
				if (port_hit(reg_addr, p, `DSHP_OFS_CAP))
					slot_capabilities[p] <= reg_wdata;
				// interlock control bit self clears
				if (port_hit(reg_addr, p, `DSHP_OFS_CTL))
					slot_control[p] <= {1'b0, reg_wdata[10:0]};
			end
		end
	end

	logic [NPORT-1:0] eic_wr;
	logic [NPORT-1:0] ctl_wr;
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			ctl_wr[p] = reg_wr && port_hit(reg_addr, p, `DSHP_OFS_CTL) && active[p];
			eic_wr[p] = ctl_wr[p] && reg_wdata[`DSHP_CTL_EIC];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interlock pulse or toggle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ilock <= '0;
			for (int p = 0; p < NPORT; p++)
				pulse_cnt[p] <= '0;
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				if (eic_wr[p] && hotplug_config_control[`DSHP_CFG_TOGGLE]) begin
					// [RULE6] toggle interlock level
					ilock[p]     <= ~ilock[p];
					pulse_cnt[p] <= '0;
				end else if (eic_wr[p]) begin
					// [RULE5] start timed pulse
					ilock[p]     <= 1'b1;
					pulse_cnt[p] <= 8'(PULSE_TICK);
				end else if (pulse_cnt[p] != '0 && tick) begin
					pulse_cnt[p] <= pulse_cnt[p] - 8'h01;
					if (pulse_cnt[p] == 8'h01)
						ilock[p] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky event flags
	logic [4:0] set_ev [NPORT];
	logic [4:0] clr_ev [NPORT];
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			set_ev[p][`DSHP_STS_ABP]   = btn_i[p] & ~btn_q[p];
			set_ev[p][`DSHP_STS_PFD]   = fault_i[p] & ~fault_q[p];
			set_ev[p][`DSHP_STS_LATCH_CHANGED_FLAG] = latch_i[p] ^ latch_q[p];
			set_ev[p][`DSHP_STS_PDC]   = pres_i[p] ^ pres_q[p];
			// [RULE11] completion only from software writes
			set_ev[p][`DSHP_STS_CC]    = ctl_wr[p];
			if (!active[p])
				set_ev[p] = '0;
			clr_ev[p] = (reg_wr && port_hit(reg_addr, p, `DSHP_OFS_STS)) ? reg_wdata[4:0] : 5'h00;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pres_q  <= '0;
			latch_q <= '0;
			btn_q   <= '0;
			fault_q <= '0;
			for (int p = 0; p < NPORT; p++)
				flags[p] <= '0;
		end else begin
			pres_q  <= pres_i;
			latch_q <= latch_i;
			btn_q   <= btn_i;
			fault_q <= fault_i;
			for (int p = 0; p < NPORT; p++)
				// [RULE24] set beats write-one clear
				flags[p] <= (flags[p] & ~clr_ev[p]) | set_ev[p];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt, wake and general event routing
	logic [NPORT-1:0] pend;
	logic [NPORT-1:0] wake;
	logic [NPORT-1:0] irq;
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			// [RULE13] unmasked pending events
			pend[p] = |(flags[p] & slot_control[p][4:0]);
			// [RULE16] completion excluded from wake
			wake[p] = |(flags[p][3:0] & slot_control[p][3:0]) & d3hot[p];
			// [RULE12] hot-plug enable gate
			irq[p]  = pend[p] & slot_control[p][`DSHP_CTL_HOTPLUG_IRQ_ENABLE];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			msi_req  <= '0;
			intx_req <= '0;
			pme_req  <= '0;
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				// [RULE17] general event mode suppresses these
				// [RULE14] msi or intx selection
				msi_req[p]  <= irq[p] & ~general_event_control[p] & msi_enable[p];
				intx_req[p] <= irq[p] & ~general_event_control[p] & ~msi_enable[p]
					& ~legacy_irq_disable[p];
				// [RULE15] wake independent of enable
				pme_req[p]  <= wake[p] & ~general_event_control[p];
			end
		end
	end

	logic [NPORT-1:0] gpe_ev;
	always_comb begin
		for (int p = 0; p < NPORT; p++)
			gpe_ev[p] = pend[p] & general_event_control[p];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			general_event_status <= '0;
			general_event_out    <= 1'b0;
			general_event_oe     <= 1'b0;
		end else begin
			// [RULE19] status only in event mode
			general_event_status <= (general_event_status
				& ~((reg_wr && reg_addr == `DSHP_ADDR_GPE_STS) ? reg_wdata[NPORT-1:0] : '0))
				| gpe_ev;
			// [RULE18] pin driven only as alternate function
			general_event_out    <= gpio_alt_func & (|gpe_ev);
			general_event_oe     <= gpio_alt_func;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// [RULE2] expander outputs
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			attention_indicator_out <= '0;
			power_indicator_out     <= '0;
			slot_power_enable_out   <= '0;
			interlock_out           <= '0;
			slot_reset_out          <= '0;
			hp_outputs_oe           <= '0;
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				attention_indicator_out[p] <= inv(slot_control[p][`DSHP_CTL_AIND_LO], 4);
				power_indicator_out[p]     <= inv(slot_control[p][`DSHP_CTL_PIND_LO], 5);
				// [RULE10] latch open forces power off
				slot_power_enable_out[p]   <= inv(~slot_control[p][`DSHP_CTL_PCC] &
					~(hotplug_config_control[`DSHP_CFG_AUTO_OFF] &
					slot_capabilities[p][`DSHP_CAP_LATCH] & latch_i[p]), 6);
				interlock_out[p]           <= inv(ilock[p], 7);
				// [RULE21] reset as gpio alternate function
				slot_reset_out[p]          <= gpio_alt_func & slot_reset_req[p];
				// [RULE22] released until enabled after reset
				hp_outputs_oe[p]           <= active[p] & expander_ready_in[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read path
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= '0;
			if (reg_addr == `DSHP_ADDR_HP_CFG)
				reg_rdata <= hotplug_config_control;
			if (reg_addr == `DSHP_ADDR_GPE_CTL)
				reg_rdata <= 32'(general_event_control);
			if (reg_addr == `DSHP_ADDR_GPE_STS)
				reg_rdata <= 32'(general_event_status);
			for (int p = 0; p < NPORT; p++) begin
				if (port_hit(reg_addr, p, `DSHP_OFS_CAP))
					reg_rdata <= slot_capabilities[p];
				// [RULE20] slot bits unchanged by event mode
				if (port_hit(reg_addr, p, `DSHP_OFS_CTL))
					reg_rdata <= 32'(slot_control[p]);
				if (port_hit(reg_addr, p, `DSHP_OFS_STS)) begin
					reg_rdata[4:0] <= flags[p];
					// [RULE8] latch reads closed in interlock mode
					reg_rdata[`DSHP_STS_LATCH] <= latch_i[p]
						& ~hotplug_config_control[`DSHP_CFG_LATCH_ILOCK];
					reg_rdata[`DSHP_STS_PRES] <= pres_i[p];
					// [RULE7] [RULE9] interlock status source
					reg_rdata[`DSHP_STS_EIS] <= hotplug_config_control[`DSHP_CFG_LATCH_ILOCK]
						? latch_i[p] : ilock[p];
				end
			end
		end else begin
			reg_rdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_toggle_inverts: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
		eic_wr[0] && hotplug_config_control[`DSHP_CFG_TOGGLE] |=> ilock[0] != $past(ilock[0]))
		else $error("toggle write did not invert interlock");
	a_pulse_starts: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
		eic_wr[0] && !hotplug_config_control[`DSHP_CFG_TOGGLE]
		|=> ilock[0] && pulse_cnt[0] == 8'(PULSE_TICK))
		else $error("interlock pulse did not start");
	a_pulse_holds: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
		ilock[0] && pulse_cnt[0] > 8'h01 && !eic_wr[0] |=> ilock[0])
		else $error("interlock pulse ended early");
	a_tick_single: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE23]
		tick |=> !tick)
		else $error("tick longer than one cycle");
	a_auto_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE10]
		hotplug_config_control[`DSHP_CFG_AUTO_OFF] && slot_capabilities[0][`DSHP_CAP_LATCH]
			&& latch_i[0]
		|=> slot_power_enable_out[0] == $past(hotplug_config_control[`DSHP_CFG_INV_LO + 6]))
		else $error("slot power not off with latch open");
	a_cc_from_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE11]
		$rose(flags[0][`DSHP_STS_CC]) |-> $past(ctl_wr[0]))
		else $error("command completed set without control write");
	a_inactive_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
		!active[0] |=> !hp_outputs_oe[0])
		else $error("outputs enabled on inactive port");
	a_irq_needs_hotplug_irq_enable: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
		(msi_req[0] | intx_req[0]) |-> $past(slot_control[0][`DSHP_CTL_HOTPLUG_IRQ_ENABLE]))
		else $error("interrupt without enable");
	a_gpe_blocks: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE17]
		$past(general_event_control[0]) |-> !msi_req[0] && !intx_req[0] && !pme_req[0])
		else $error("pcie event in general event mode");
	a_cc_no_wake: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE16]
		pme_req[0] |-> |($past(flags[0][3:0]) & $past(slot_control[0][3:0])))
		else $error("wake from completion only");
	a_wake_d3: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE15]
		pme_req[0] |-> $past(d3hot[0]))
		else $error("wake request outside low power");
	a_msi_sel: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE14]
		msi_req[0] |-> !intx_req[0] && $past(msi_enable[0]))
		else $error("wrong delivery selection");
	a_intx_sel: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE14]
		intx_req[0] |-> !$past(msi_enable[0]) && !$past(legacy_irq_disable[0]))
		else $error("legacy interrupt against enable bits");
	a_latch_closed: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
		reg_rd && port_hit(reg_addr, 0, `DSHP_OFS_STS)
			&& hotplug_config_control[`DSHP_CFG_LATCH_ILOCK] |=> !reg_rdata[`DSHP_STS_LATCH])
		else $error("latch state not closed in interlock mode");
	a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE24]
		flags[0][0] && clr_ev[0][0] == 1'b0 |=> flags[0][0])
		else $error("flag lost without clear");
	a_gpe_status: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE19]
		$rose(general_event_status[0]) |-> $past(general_event_control[0]))
		else $error("general status set outside mode");
	a_gpio_alt: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE18]
		general_event_out |-> $past(gpio_alt_func))
		else $error("general event pin without alternate function");
	c_pulse: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(ilock[0]));
	c_msi: cover property (@(posedge ref_clk) disable iff (!rst_n) msi_req[0]);
	c_pme: cover property (@(posedge ref_clk) disable iff (!rst_n) pme_req[0]);
	c_gpe: cover property (@(posedge ref_clk) disable iff (!rst_n) general_event_out);
endmodule : dshp_ctrl

/* tb/dshp_expander_model.sv */
// behavioural slot-side expander: sensors toward the switch, power good back
`timescale 1ns/10ps
module dshp_expander_model #(
	parameter int NPORT     = 5,
	parameter int READY_DLY = 10
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [NPORT-1:0] card_fitted,
	input  wire logic [NPORT-1:0] latch_open,
	input  wire logic [NPORT-1:0] button_held,
	input  wire logic [NPORT-1:0] fault_seen,
	input  wire logic [NPORT-1:0] slot_power_enable_out,
	output logic      [NPORT-1:0] attention_button_in,
	output logic      [NPORT-1:0] presence_detect_in,
	output logic      [NPORT-1:0] power_fault_in,
	output logic      [NPORT-1:0] retention_latch_in,
	output logic      [NPORT-1:0] slot_power_good_in,
	output logic      [NPORT-1:0] expander_ready_in
);
	int unsigned ready_cnt;
	assign presence_detect_in = card_fitted;
	assign attention_button_in = button_held;
	assign power_fault_in = fault_seen;
	assign retention_latch_in = latch_open;
	////////////////////////////////////////////////////////////////
	// expander init, power good
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_cnt <= 0;
			expander_ready_in <= '0;
			slot_power_good_in <= '0;
		end else begin
			// power good lags enable by one cycle, like a real supply
			slot_power_good_in <= slot_power_enable_out;
			if (ready_cnt < READY_DLY) begin
				ready_cnt <= ready_cnt + 1;
			end else begin
				expander_ready_in <= '1;
			end
		end
	end
endmodule : dshp_expander_model

/* tb/dshp_ctrl_bench.sv */
// self-checking bench for the slot hot-plug controller
`timescale 1ns/10ps
`include "dshp_regs.svh"
module dshp_ctrl_bench;
	import dshp_pkg::*;
	localparam int         TDIV = 4;
	localparam logic [7:0] CAP0 = 8'h10;
	localparam logic [7:0] CTL0 = 8'h14;
	localparam logic [7:0] STS0 = 8'h18;
	localparam logic [7:0] CTL1 = 8'h24;
	logic       ref_clk, rst_n, reg_wr, reg_rd, gev, gev_oe, alt;
	logic [7:0] reg_addr;
	dshp_word_t reg_wdata, rv;
	logic [31:0] reg_rdata;
	logic [4:0] btn_in, pres_in, flt_in, lat_in, pgood, rdy;
	logic [4:0] aind, pind, pwr_en, ilock, srst, oe, msi, intx, pme;
	logic [4:0] card, latch_open, press, fault, msi_en, intx_dis, d3, srst_req;
	int         fails = 0, check_count = 0, cyc = 0;

	dshp_ctrl #(.NPORT(5), .TICK_DIV(TDIV), .PULSE_TICK(125)) i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.attention_button_in(btn_in), .presence_detect_in(pres_in),
		.power_fault_in(flt_in), .retention_latch_in(lat_in),
		.slot_power_good_in(pgood), .expander_ready_in(rdy),
		.attention_indicator_out(aind), .power_indicator_out(pind),
		.slot_power_enable_out(pwr_en), .interlock_out(ilock), .slot_reset_out(srst),
		.hp_outputs_oe(oe), .msi_req(msi), .intx_req(intx), .pme_req(pme),
		.general_event_out(gev), .general_event_oe(gev_oe), .msi_enable(msi_en),
		.legacy_irq_disable(intx_dis), .d3hot(d3), .gpio_alt_func(alt),
		.slot_reset_req(srst_req));
	dshp_expander_model #(.NPORT(5), .READY_DLY(10)) i_exp (
		.ref_clk(ref_clk), .rst_n(rst_n), .card_fitted(card), .latch_open(latch_open),
		.button_held(press), .fault_seen(fault), .slot_power_enable_out(pwr_en),
		.attention_button_in(btn_in), .presence_detect_in(pres_in),
		.power_fault_in(flt_in), .retention_latch_in(lat_in),
		.slot_power_good_in(pgood), .expander_ready_in(rdy));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input dshp_word_t got, input dshp_word_t exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : settle
	task automatic wr(input logic [7:0] a, input dshp_word_t d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output dshp_word_t d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge ref_clk);
	endtask : rd
	////////////////////////////////////////////////////////////////
	// port enable, defaults
	task automatic t_enable();
		rd(`DSHP_ADDR_HP_CFG, rv);
		chk(rv, `DSHP_CFG_RESET);
		rd(CAP0, rv);
		chk(rv, `DSHP_CAP_RESET);
		rd(8'hFC, rv);
		chk(rv, 32'h0000_0000);
		rd(STS0, rv);
		chk(rv[4], 1'b0);
		wr(CAP0, 32'h0000_0046);
		wr(CTL0, 32'h0000_0140);
		wr(CTL1, 32'h0000_0800);
		settle(20);
		chk({aind[0], pind[0]}, 2'b11);
		chk({oe, ilock[1]}, 6'h02);
	endtask : t_enable
	task automatic t_invert();
		rd(STS0, rv);
		chk(rv[6], 1'b0);
		wr(`DSHP_ADDR_HP_CFG, 32'h0000_0002);
		settle(6);
		rd(STS0, rv);
		chk(rv[6], 1'b1);
		wr(`DSHP_ADDR_HP_CFG, 32'h0000_0000);
		wr(STS0, 32'h0000_001F);
	endtask : t_invert
	task automatic t_pulse();
		int n;
		wr(CTL0, 32'h0000_0800);
		repeat (10) if (ilock[0] !== 1'b1) @(posedge ref_clk);
		rd(STS0, rv);
		chk(rv[7], 1'b1);
		n = 2;
		while (ilock[0] === 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		chk(n > 100 * TDIV && n < 150 * TDIV, 1'b1);
		rd(STS0, rv);
		chk(rv[7], 1'b0);
	endtask : t_pulse
	task automatic t_toggle();
		wr(`DSHP_ADDR_HP_CFG, 32'h0000_0100);
		wr(CTL0, 32'h0000_0800);
		settle(700);
		chk(ilock[0], 1'b1);
		wr(CTL0, 32'h0000_0800);
		settle(8);
		chk(ilock[0], 1'b0);
		wr(`DSHP_ADDR_HP_CFG, 32'h0000_0000);
	endtask : t_toggle
	task automatic t_latch();
		wr(`DSHP_ADDR_HP_CFG, 32'h0000_0200);
		latch_open[0] <= 1'b1;
		settle(10);
		rd(STS0, rv);
		chk({rv[7], rv[5]}, 2'b10);
		latch_open[0] <= 1'b0;
		wr(CTL0, 32'h0000_0000);
		settle(10);
		chk(pwr_en[0], 1'b1);
		wr(`DSHP_ADDR_HP_CFG, 32'h0000_0400);
		latch_open[0] <= 1'b1;
		settle(10);
		wr(CTL0, 32'h0000_0000);
		settle(4);
		chk(pwr_en[0], 1'b0);
		latch_open[0] <= 1'b0;
		settle(10);
		chk(pwr_en[0], 1'b1);
		wr(`DSHP_ADDR_HP_CFG, 32'h0000_0000);
		wr(STS0, 32'h0000_001F);
	endtask : t_latch
	task automatic t_irq();
		msi_en[0] <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			wr(CTL0, (32'h0000_0001 << i) | 32'h0000_0020);
			case (i)
				0: press[0] <= 1'b1;
				1: fault[0] <= 1'b1;
				2: latch_open[0] <= 1'b1;
				3: card[0] <= ~card[0];
				default: ;
			endcase
			settle(10);
			chk(msi[0], 1'b1);
			press[0] <= 1'b0;
			fault[0] <= 1'b0;
			latch_open[0] <= 1'b0;
			settle(10);
			wr(STS0, 32'h0000_001F);
			settle(4);
			chk(msi[0], 1'b0);
		end
		for (int m = 0; m < 2; m++) begin
			wr(CTL0, m == 0 ? 32'h0000_0020 : 32'h0000_0008);
			card[0] <= ~card[0];
			settle(10);
			chk(msi[0], 1'b0);
		end
		wr(CTL0, 32'h0000_0028);
		for (int m = 0; m < 3; m++) begin
			msi_en[0] <= (m == 0);
			intx_dis[0] <= (m == 2);
			settle(6);
			chk({msi[0], intx[0]}, m == 0 ? 2'b10 : m == 1 ? 2'b01 : 2'b00);
		end
		wr(STS0, 32'h0000_001F);
	endtask : t_irq
	task automatic t_wake();
		d3[0] <= 1'b1;
		msi_en[0] <= 1'b1;
		for (int m = 0; m < 3; m++) begin
			wr(CTL0, m == 0 ? 32'h0000_0008 : m == 1 ? 32'h0000_0028 : 32'h0000_0020);
			wr(STS0, 32'h0000_001F);
			card[0] <= ~card[0];
			settle(10);
			chk({pme[0], msi[0]}, m == 0 ? 2'b10 : m == 1 ? 2'b11 : 2'b00);
		end
		wr(STS0, 32'h0000_001F);
		wr(CTL0, 32'h0000_0010);
		settle(10);
		chk(pme[0], 1'b0);
		wr(STS0, 32'h0000_001F);
	endtask : t_wake
	task automatic t_gpe();
		wr(`DSHP_ADDR_GPE_CTL, 32'h0000_0001);
		wr(CTL0, 32'h0000_0028);
		wr(STS0, 32'h0000_001F);
		srst_req[0] <= 1'b1;
		card[0] <= ~card[0];
		settle(10);
		chk({gev, msi[0], pme[0]}, 3'b000);
		chk({gev_oe, srst[0]}, 2'b00);
		rd(STS0, rv);
		chk(rv[3], 1'b1);
		rd(`DSHP_ADDR_GPE_STS, rv);
		chk(rv[0], 1'b1);
		alt <= 1'b1;
		settle(4);
		chk({gev_oe, srst[0], gev}, 3'b111);
		wr(`DSHP_ADDR_GPE_CTL, 32'h0000_0000);
		wr(STS0, 32'h0000_001F);
		wr(`DSHP_ADDR_GPE_STS, 32'h0000_0001);
		card[0] <= ~card[0];
		settle(10);
		rd(`DSHP_ADDR_GPE_STS, rv);
		chk(rv[0], 1'b0);
		d3[0] <= 1'b0;
	endtask : t_gpe
	////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	// hang guard: whole sequence needs well under this many cycles
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		{rst_n, reg_wr, reg_rd, alt, reg_addr, reg_wdata} = '0;
		{card, latch_open, press, fault, msi_en, intx_dis, d3, srst_req} = '0;
		settle(3);
		chk({oe, ilock, pwr_en, srst, gev_oe}, 21'h00_0000);
		settle(3);
		rst_n <= 1'b1;
		settle(2);
		t_enable();
		t_invert();
		t_pulse();
		t_toggle();
		t_latch();
		t_irq();
		t_wake();
		t_gpe();
		report_and_stop();
	end
endmodule : dshp_ctrl_bench
